// *** logic/backwash_pkg.sv ***
package backwash_pkg;

    localparam int CLK_HZ = 40_000_000;
    localparam int NUM_TANKS = 8;
    localparam int CLOSE_MIN_MS = 100;
    localparam int OPEN_MIN_MS = 500;
    localparam int CLOSE_CYCLES = (CLOSE_MIN_MS * (CLK_HZ / 1000));
    localparam int OPEN_CYCLES = (OPEN_MIN_MS * (CLK_HZ / 1000));
    localparam int DWELL_MS = 60_000;
    localparam int ALARM_COUNT = 4;
    localparam logic [7:0] STATION_RST = 8'h00;
    localparam logic [2:0] START_RST = 3'h0;

    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_IRQ_STAT = 32'h0000_0008;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'h0000_000C;
    localparam logic [31:0] ADDR_DWELL = 32'h0000_0010;

    localparam int IRQ_START = 0;
    localparam int IRQ_STEP = 1;
    localparam int IRQ_ALARM = 2;
    localparam int IRQ_DONE = 3;
    localparam int IRQ_W = 4;

    typedef enum logic [1:0] {
        ST_FILTER,
        ST_WASH
    } wash_state_e;

    typedef struct packed {
        logic [7:0] station;
        logic main_valve;
        logic aux_relay;
        logic alarm;
    } drive_s;

endpackage

// *** logic/filter_backwash_sequencer.sv ***
// Behaviour
// - The main-valve output is on for the whole backwash and off again in filtering.
// - With the pressure trip still active after a wash, the fourth consecutive start raises the alarm.
// - While the alarm is up a prompt flag is shown, and the plus key clears alarm and prompt.
// - An accepted remote closure starts a backwash regardless of the function selector.
// - A remote closure counts only after lasting at least 100 ms.
// - Contacts that stay closed after an accepted closure are ignored until they open.
// - An opening of at least half a second followed by a valid closure steps one tank.
// - Eight tank station outputs are driven besides the main-valve output.
// - The auxiliary relay output is energised while a backwash runs.
// - Each new backwash starts at the tank after the previous start tank.
`timescale 1ns/1ps
`default_nettype none
module filter_backwash_sequencer
    import backwash_pkg::*;
#(
    parameter int CLOSE_CYC = CLOSE_CYCLES,
    parameter int OPEN_CYC = OPEN_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic remote_start_contacts,
    input wire logic pressure_trip,
    input wire logic plus_key,
    input wire logic selector_start,
    output logic [7:0] station_out,
    output logic main_valve_out,
    output logic aux_relay_out,
    output logic alarm_out,
    output logic alarm_prompt,
    output logic irq
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic rs_s;
    logic pd_s;
    logic key_s;
    logic key_d_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            key_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {plus_key, pressure_trip, remote_start_contacts};
            sync2_reg <= sync1_reg;
            key_d_reg <= sync2_reg[2];
        end
    end
    assign rs_s = sync2_reg[0];
    assign pd_s = sync2_reg[1];
    assign key_s = sync2_reg[2] & ~key_d_reg;

    // ------------------------------------------------------------
    // Remote contact timing
    // ------------------------------------------------------------
    // Open time saturates, so a long idle gap still qualifies a step
    logic [31:0] close_cnt_reg;
    logic [31:0] open_cnt_reg;
    logic armed_reg;
    logic open_ok_reg;
    logic remote_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            close_cnt_reg <= 32'h0000_0000;
            open_cnt_reg <= 32'h0000_0000;
            armed_reg <= 1'b1;
            open_ok_reg <= 1'b1;
        end else if (rs_s) begin
            open_cnt_reg <= 32'h0000_0000;
            if (close_cnt_reg < 32'(CLOSE_CYC)) begin
                close_cnt_reg <= close_cnt_reg + 32'h0000_0001;
            end
            if (remote_hit) begin
                armed_reg <= 1'b0;
                open_ok_reg <= 1'b0;
            end
        end else begin
            close_cnt_reg <= 32'h0000_0000;
            if (open_cnt_reg < 32'(OPEN_CYC)) begin
                open_cnt_reg <= open_cnt_reg + 32'h0000_0001;
            end else begin
                open_ok_reg <= 1'b1;
            end
            if (open_cnt_reg >= 32'(OPEN_CYC)) begin
                armed_reg <= 1'b1;
            end
        end
    end
    assign remote_hit = rs_s && armed_reg && open_ok_reg
                        && (close_cnt_reg == 32'(CLOSE_CYC) - 32'h0000_0001);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic enable_reg;
    logic [31:0] dwell_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic wr_en;
    logic [IRQ_W-1:0] ev;

    assign wr_en = psel && penable && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg <= 1'b1;
            dwell_reg <= 32'(DWELL_MS) * 32'(CLK_HZ / 1000);
            irq_mask_reg <= '0;
        end else if (wr_en) begin
            if (paddr == ADDR_CTRL) begin
                enable_reg <= pwdata[0];
            end else if (paddr == ADDR_IRQ_MASK) begin
                irq_mask_reg <= pwdata[IRQ_W-1:0];
            end else if (paddr == ADDR_DWELL) begin
                dwell_reg <= pwdata;
            end
        end
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
        end else if (wr_en && paddr == ADDR_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | ev;
        end else begin
            irq_stat_reg <= irq_stat_reg | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    wash_state_e state_reg;
    logic [2:0] tank_reg;
    logic [2:0] start_tank_reg;
    logic [2:0] steps_reg;
    logic [31:0] dwell_cnt_reg;
    logic [2:0] retry_cnt_reg;
    logic pd_after_reg;
    logic start_req;
    logic step_req;
    logic done;

    // Enable gates the local selector only; a remote closure always starts
    assign start_req = (state_reg == ST_FILTER)
                       && (remote_hit || (enable_reg && selector_start));
    assign step_req = (state_reg == ST_WASH) && remote_hit;
    assign done = (state_reg == ST_WASH) && (steps_reg == 3'h7)
                  && (step_req || dwell_cnt_reg >= dwell_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_FILTER;
            tank_reg <= START_RST;
            start_tank_reg <= START_RST;
            steps_reg <= 3'h0;
            dwell_cnt_reg <= 32'h0000_0000;
        end else begin
            case (state_reg)
                ST_FILTER: begin
                    if (start_req) begin
                        state_reg <= ST_WASH;
                        tank_reg <= start_tank_reg;
                        start_tank_reg <= start_tank_reg + 3'h1;
                        steps_reg <= 3'h0;
                        dwell_cnt_reg <= 32'h0000_0000;
                    end
                end
                ST_WASH: begin
                    if (done) begin
                        state_reg <= ST_FILTER;
                    end else if (step_req || dwell_cnt_reg >= dwell_reg) begin
                        tank_reg <= tank_reg + 3'h1;
                        steps_reg <= steps_reg + 3'h1;
                        dwell_cnt_reg <= 32'h0000_0000;
                    end else begin
                        dwell_cnt_reg <= dwell_cnt_reg + 32'h0000_0001;
                    end
                end
                default: begin
                    state_reg <= ST_FILTER;
                end
            endcase
        end
    end

    assign ev = {done, 1'b0, step_req, start_req} | ({IRQ_W{1'b0}} | (IRQ_W'(
                (retry_cnt_reg == 3'(ALARM_COUNT - 1)) && start_req && pd_after_reg)
                << IRQ_ALARM));

    // ------------------------------------------------------------
    // Pressure alarm
    // ------------------------------------------------------------
    // Trip sampled at cycle end; a start with no trip resets the run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_after_reg <= 1'b0;
            retry_cnt_reg <= 3'h0;
            alarm_out <= 1'b0;
            alarm_prompt <= 1'b0;
        end else begin
            if (done) begin
                pd_after_reg <= pd_s;
            end
            if (start_req) begin
                if (!pd_after_reg) begin
                    retry_cnt_reg <= 3'h1;
                end else if (retry_cnt_reg < 3'(ALARM_COUNT)) begin
                    retry_cnt_reg <= retry_cnt_reg + 3'h1;
                end
            end
            if (start_req && pd_after_reg && retry_cnt_reg == 3'(ALARM_COUNT - 1)) begin
                alarm_out <= 1'b1;
                alarm_prompt <= 1'b1;
            end else if (key_s) begin
                alarm_out <= 1'b0;
                alarm_prompt <= 1'b0;
                retry_cnt_reg <= 3'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            station_out <= STATION_RST;
            main_valve_out <= 1'b0;
            aux_relay_out <= 1'b0;
        end else begin
            station_out <= (state_reg == ST_WASH) ? (8'h01 << tank_reg) : 8'h00;
            main_valve_out <= (state_reg == ST_WASH);
            aux_relay_out <= (state_reg == ST_WASH);
        end
    end

    // ------------------------------------------------------------
    // APB read side
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                if (paddr == ADDR_CTRL) begin
                    prdata <= {31'h0, enable_reg};
                end else if (paddr == ADDR_STATUS) begin
                    prdata <= {15'h0, station_out, 1'b0, retry_cnt_reg,
                               alarm_out, tank_reg, (state_reg == ST_WASH)};
                end else if (paddr == ADDR_IRQ_STAT) begin
                    prdata <= {28'h0, irq_stat_reg};
                end else if (paddr == ADDR_IRQ_MASK) begin
                    prdata <= {28'h0, irq_mask_reg};
                end else if (paddr == ADDR_DWELL) begin
                    prdata <= dwell_reg;
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_main_valve;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> (main_valve_out == $past(state_reg == ST_WASH));
    endproperty
    a_main_valve: assert property (p_main_valve) else $error("main valve mismatch");

    property p_one_hot;
        @(posedge pclk) disable iff (!presetn)
        $onehot0(station_out);
    endproperty
    a_one_hot: assert property (p_one_hot) else $error("two stations on");

    property p_aux;
        @(posedge pclk) disable iff (!presetn)
        start_req |=> ##1 aux_relay_out;
    endproperty
    a_aux: assert property (p_aux) else $error("aux relay not on");

    sequence s_held_after_hit;
        remote_hit ##1 rs_s [*8];
    endsequence

    property p_hold_ignored;
        @(posedge pclk) disable iff (!presetn)
        s_held_after_hit |-> !remote_hit && !armed_reg;
    endproperty
    a_hold_ignored: assert property (p_hold_ignored) else $error("held contact acted");

    sequence s_no_hit;
        (!remote_hit) [*8];
    endsequence

    property p_short_close;
        @(posedge pclk) disable iff (!presetn)
        $rose(rs_s) |-> s_no_hit;
    endproperty
    a_short_close: assert property (p_short_close) else $error("closure too short");

    property p_rotate;
        @(posedge pclk) disable iff (!presetn)
        start_req |=> (tank_reg == $past(start_tank_reg));
    endproperty
    a_rotate: assert property (p_rotate) else $error("start tank wrong");

    property p_alarm_clear;
        @(posedge pclk) disable iff (!presetn)
        (key_s && !start_req) |=> !alarm_out && !alarm_prompt;
    endproperty
    a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared");

    property p_alarm_set;
        @(posedge pclk) disable iff (!presetn)
        $rose(alarm_out) |-> $past(retry_cnt_reg) == 3'(ALARM_COUNT - 1);
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm count wrong");

    property p_step;
        @(posedge pclk) disable iff (!presetn)
        (step_req && !done) |=> tank_reg == $past(tank_reg) + 3'h1;
    endproperty
    a_step: assert property (p_step) else $error("no tank step");

endmodule // filter_backwash_sequencer
`default_nettype wire

// *** sim/remote_contacts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Remote switch or relay contacts
// ----------------------------------------
module remote_contacts (
    input wire logic pclk,
    output logic contacts
);
    // Open contacts read low; no bounce modelled, the bench times each phase
    initial contacts = 1'b0;

    // One closure of c cycles, then an opening of o cycles
    task automatic press(input int c, input int o);
        contacts <= 1'b1;
        repeat (c) @(posedge pclk);
        contacts <= 1'b0;
        repeat (o) @(posedge pclk);
    endtask
endmodule // remote_contacts
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import backwash_pkg::*;
    // ----------------------------------------
    // Short counts keep the run small
    // ----------------------------------------
    localparam int CC = 20;
    localparam int OC = 50;
    localparam int LIMIT = 30000;
    logic pclk, presetn, psel, penable, pwrite;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic pready, pslverr, er, pressure_trip, plus_key, selector_start;
    logic remote_start_contacts, main_valve_out, aux_relay_out, alarm_out, alarm_prompt, irq;
    logic [7:0] station_out;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;

    filter_backwash_sequencer #(.CLOSE_CYC(CC), .OPEN_CYC(OC)) u_filter_backwash_sequencer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .remote_start_contacts(remote_start_contacts), .pressure_trip(pressure_trip),
        .plus_key(plus_key), .selector_start(selector_start), .station_out(station_out),
        .main_valve_out(main_valve_out), .aux_relay_out(aux_relay_out),
        .alarm_out(alarm_out), .alarm_prompt(alarm_prompt), .irq(irq));
    remote_contacts u_remote_contacts (.pclk(pclk), .contacts(remote_start_contacts));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic close_out();
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic step(input logic [7:0] exp);
        u_remote_contacts.press(CC + 5, OC + 5);
        chk(station_out, exp);
    endtask

    task automatic finish_wash();
        repeat (8) u_remote_contacts.press(CC + 5, OC + 5);
        chk({main_valve_out, aux_relay_out, station_out}, 0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        chk({station_out, main_valve_out, aux_relay_out, alarm_out, alarm_prompt, irq}, 0);
        apb(1'b0, ADDR_CTRL, 0);
        chk(rd, 32'h0000_0001);
        apb(1'b0, ADDR_IRQ_MASK, 0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 32'h0000_0020, 0);
        chk({er, rd}, {1'b1, 32'h0000_0000});
        // Long dwell so only remote closures move the tanks
        apb(1'b1, ADDR_DWELL, 32'h0001_0000);
        apb(1'b0, ADDR_DWELL, 0);
        chk(rd, 32'h0001_0000);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    endtask

    task automatic t_remote();
        int k;
        u_remote_contacts.press(CC - 8, OC + 5);
        chk(main_valve_out, 1'b0);
        u_remote_contacts.press(CC * 4, OC + 5);
        chk({main_valve_out, aux_relay_out}, 2'b11);
        chk(station_out, 8'h01);
        chk(irq, 1'b1);
        apb(1'b0, ADDR_IRQ_STAT, 0);
        chk(rd[IRQ_START], 1'b1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0001);
        // Status clears at the access edge, the registered line one edge later
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        u_remote_contacts.press(CC + 5, OC - 15);
        chk(station_out, 8'h02);
        step(8'h02);
        for (k = 2; k < 8; k++) begin
            step(8'h01 << k);
        end
        u_remote_contacts.press(CC + 5, OC + 5);
        chk({main_valve_out, aux_relay_out, station_out}, 0);
    endtask

    task automatic t_rotate();
        step(8'h02);
        chk(main_valve_out, 1'b1);
        finish_wash();
    endtask

    task automatic t_alarm();
        int k;
        apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0004);
        pressure_trip <= 1'b1;
        repeat (10) @(posedge pclk);
        for (k = 1; k <= 4; k++) begin
            u_remote_contacts.press(CC + 5, OC + 5);
            chk({alarm_out, alarm_prompt}, (k == 4) ? 2'b11 : 2'b00);
            if (k < 4) begin
                finish_wash();
            end
        end
        chk(irq, 1'b1);
        pressure_trip <= 1'b0;
        plus_key <= 1'b1;
        repeat (6) @(posedge pclk);
        plus_key <= 1'b0;
        repeat (6) @(posedge pclk);
        chk({alarm_out, alarm_prompt}, 2'b00);
        finish_wash();
    endtask

    task automatic t_select();
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        selector_start <= 1'b1;
        repeat (4) @(posedge pclk);
        selector_start <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(main_valve_out, 1'b0);
        u_remote_contacts.press(CC + 5, OC + 5);
        chk({main_valve_out, station_out}, {1'b1, 8'h40});
        apb(1'b0, ADDR_STATUS, 0);
        chk(rd[3:0], 4'hD);
        finish_wash();
        // Short dwell: this wash ends on the per-tank timer alone
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        apb(1'b1, ADDR_DWELL, 32'h0000_0020);
        selector_start <= 1'b1;
        @(posedge pclk);
        selector_start <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(station_out, 8'h80);
        repeat (400) @(posedge pclk);
        chk({main_valve_out, aux_relay_out, station_out}, 0);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 0;
        pwdata = 0;
        pressure_trip = 1'b0;
        plus_key = 1'b0;
        selector_start = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_remote();
        t_rotate();
        t_alarm();
        t_select();
        close_out();
    end
endmodule // testbench
`default_nettype wire
